// ===== verilog/imu_sync_pkg.sv
package imu_sync_pkg;

  localparam longint unsigned CLK_HZ = 100_000_000;
  localparam longint unsigned INTERNAL_RATE_HZ = 2000;
  localparam int unsigned INTERNAL_PERIOD_CYCLES = int'(CLK_HZ / INTERNAL_RATE_HZ);
  localparam longint unsigned DR_PULSE_NS = 5000;
  localparam int unsigned DR_PULSE_CYCLES = int'((DR_PULSE_NS * CLK_HZ + 999_999_999) / 1_000_000_000);
  localparam longint unsigned SYNC_OUT_PULSE_NS = 1000;
  localparam int unsigned SYNC_OUT_CYCLES = int'((SYNC_OUT_PULSE_NS * CLK_HZ + 999_999_999) / 1_000_000_000);

  localparam logic [6:0] ADDR_GYRO_RANGE = 7'h5E;
  localparam logic [6:0] ADDR_MISC_CTRL = 7'h60;
  localparam logic [6:0] ADDR_CLOCK_SCALE = 7'h62;
  localparam logic [6:0] ADDR_DECIMATION = 7'h64;

  localparam logic [15:0] MISC_CTRL_RESET = 16'h00C1;
  localparam logic [15:0] CLOCK_SCALE_RESET = 16'h07D0;
  localparam logic [15:0] DECIMATION_RESET = 16'h0000;
  localparam logic [1:0] RANGE_LOW_BITS = 2'h3;

  localparam int unsigned CMD_WRITE_BIT = 15;
  localparam int unsigned CMD_ADDR_MSB = 14;
  localparam int unsigned CMD_ADDR_LSB = 8;
  localparam int unsigned CTRL_LINEAR_G = 7;
  localparam int unsigned CTRL_PERCUSSION = 6;
  localparam int unsigned CTRL_UNUSED = 5;
  localparam int unsigned CTRL_MODE_MSB = 4;
  localparam int unsigned CTRL_MODE_LSB = 2;
  localparam int unsigned CTRL_SYNC_POL = 1;
  localparam int unsigned CTRL_DV_POL = 0;
  localparam int unsigned DEC_MSB = 10;

  localparam int unsigned PERIOD_W = 28;
  localparam int unsigned DEC_W = 11;

  typedef enum logic [2:0] {
    MODE_INTERNAL = 3'h0,
    MODE_DIRECT = 3'h1,
    MODE_SCALED = 3'h2,
    MODE_OUTPUT = 3'h3,
    MODE_PULSE = 3'h5
  } sync_mode_t;

  typedef struct packed {
    logic valid;
    logic [15:0] word;
  } serial_cmd_t;

  typedef struct packed {
    logic gyro;
    logic accel;
    logic accel_pair_done;
  } sample_strobes_t;

endpackage : imu_sync_pkg

// ===== verilog/sample_clock_gen.sv
`timescale 1ns/1ps
`default_nettype none
module sample_clock_gen
  import imu_sync_pkg::*;
#(
  parameter int unsigned PERIOD_CYCLES = INTERNAL_PERIOD_CYCLES
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic sync_edge,
  input wire logic [15:0] scale,
  output logic int_tick,
  output logic int_half_tick,
  output logic scaled_tick
);

  typedef struct packed {
    logic [PERIOD_W-1:0] timer;
    logic [PERIOD_W-1:0] sync_count;
    logic [PERIOD_W-1:0] sync_period;
    logic [PERIOD_W-1:0] acc;
    logic int_tick;
    logic int_half_tick;
    logic scaled_tick;
  } gen_state_t;

  localparam logic [PERIOD_W-1:0] LAST = PERIOD_W'(PERIOD_CYCLES - 1);
  localparam logic [PERIOD_W-1:0] HALF = PERIOD_W'(PERIOD_CYCLES / 2 - 1);

  gen_state_t state;
  gen_state_t next_state;

  always_comb begin
    logic [PERIOD_W-1:0] sum;
    sum = '0;
    next_state = state;
    next_state.int_tick = 1'b0;
    next_state.int_half_tick = 1'b0;
    next_state.scaled_tick = 1'b0;
    // free-running internal timebase, also used to retire stale modes
    if (state.timer == LAST) begin
      next_state.timer = '0;
      next_state.int_tick = 1'b1;
      next_state.int_half_tick = 1'b1;
    end else begin
      next_state.timer = state.timer + 1'b1;
      if (state.timer == HALF) begin
        next_state.int_half_tick = 1'b1;
      end
    end
    // sync period measured in clocks; saturates when the reference stops
    if (sync_edge) begin
      next_state.sync_period = state.sync_count + 1'b1;
      next_state.sync_count = '0;
    end else if (state.sync_count != '1) begin
      next_state.sync_count = state.sync_count + 1'b1;
    end
    // rate = scale / period, no divider needed; scale above period caps at clk
    sum = state.acc + PERIOD_W'(scale);
    if (state.sync_period != '0 && sum >= state.sync_period) begin
      next_state.acc = sum - state.sync_period;
      next_state.scaled_tick = 1'b1;
    end else if (state.sync_period != '0) begin
      next_state.acc = sum;
    end
    if (!reset_n) begin
      next_state = '0;
    end
  end

  always_ff @(posedge clk) begin
    state <= next_state;
  end

  assign int_tick = state.int_tick;
  assign int_half_tick = state.int_half_tick;
  assign scaled_tick = state.scaled_tick;

endmodule : sample_clock_gen
`default_nettype wire

// ===== verilog/output_decimator.sv
`timescale 1ns/1ps
`default_nettype none
module output_decimator
  import imu_sync_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic sample_tick,
  input wire logic [DEC_W-1:0] divisor,
  output logic out_tick,
  output logic dv_active
);

  typedef struct packed {
    logic [DEC_W-1:0] count;
    logic [15:0] hold;
    logic out_tick;
    logic dv_active;
  } dec_state_t;

  dec_state_t state;
  dec_state_t next_state;

  always_comb begin
    next_state = state;
    next_state.out_tick = 1'b0;
    if (state.hold != '0) begin
      next_state.hold = state.hold - 1'b1;
    end
    next_state.dv_active = (state.hold > 16'h0001);
    if (sample_tick) begin
      // divisor lowered below count restarts the period
      if (state.count >= divisor) begin
        next_state.count = '0;
        next_state.out_tick = 1'b1;
        next_state.hold = 16'(DR_PULSE_CYCLES);
        next_state.dv_active = 1'b1;
      end else begin
        next_state.count = state.count + 1'b1;
        // next sample starts a new average, so the pin drops once per output
        next_state.hold = '0;
        next_state.dv_active = 1'b0;
      end
    end
    if (!reset_n) begin
      next_state = '0;
    end
  end

  always_ff @(posedge clk) begin
    state <= next_state;
  end

  assign out_tick = state.out_tick;
  assign dv_active = state.dv_active;

endmodule : output_decimator
`default_nettype wire

// ===== verilog/imu_sample_clock_sync_control.sv
`timescale 1ns/1ps
`default_nettype none
module imu_sample_clock_sync_control
  import imu_sync_pkg::*;
#(
  parameter int unsigned SAMPLE_PERIOD_CYCLES = INTERNAL_PERIOD_CYCLES,
  parameter logic [1:0] GYRO_RANGE = 2'h3
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire serial_cmd_t cmd,
  output logic [15:0] rd_data,
  output logic rd_valid,
  input wire logic sync_in,
  output logic sync_out,
  output logic sync_oe_n,
  output logic data_valid_pin,
  output sample_strobes_t strobes,
  output logic output_strobe,
  output logic linear_g_comp_en,
  output logic percussion_align_en,
  output logic bandwidth_reduced
);

  typedef struct packed {
    logic [15:0] misc_ctrl;
    logic [15:0] clock_scale;
    logic [15:0] decimation;
    logic [15:0] rd_data;
    logic rd_valid;
    logic sync_meta;
    logic sync_level;
    logic sync_prev;
    logic [2:0] active_mode;
    logic accel_half;
    logic [15:0] sync_out_cnt;
    logic sync_out;
    logic sync_oe_n;
    logic data_valid_pin;
    sample_strobes_t strobes;
    logic output_strobe;
    logic linear_g;
    logic percussion;
    logic bw_reduced;
  } top_state_t;

  top_state_t state;
  top_state_t next_state;

  // pulse clipped to half a sample period so the pin returns idle between samples
  localparam int unsigned SYNC_OUT_MAX = SAMPLE_PERIOD_CYCLES / 2;
  localparam logic [15:0] SYNC_OUT_LEN = 16'((SYNC_OUT_CYCLES < SYNC_OUT_MAX) ? SYNC_OUT_CYCLES : SYNC_OUT_MAX);

  logic int_tick;
  logic int_half_tick;
  logic scaled_tick;
  logic dec_tick;
  logic dv_active;
  logic active_edge;
  logic other_edge;

  function automatic logic [2:0] mode_legal(input logic [2:0] code);
    // reserved codes fall back to internal timing
    case (code)
      MODE_INTERNAL, MODE_DIRECT, MODE_SCALED, MODE_OUTPUT, MODE_PULSE: mode_legal = code;
      default: mode_legal = MODE_INTERNAL;
    endcase
  endfunction : mode_legal

  function automatic logic [15:0] reg_read(input logic [6:0] addr, input top_state_t s);
    case (addr)
      ADDR_GYRO_RANGE: reg_read = {12'h000, GYRO_RANGE, RANGE_LOW_BITS};
      ADDR_MISC_CTRL: reg_read = s.misc_ctrl;
      ADDR_CLOCK_SCALE: reg_read = s.clock_scale;
      ADDR_DECIMATION: reg_read = s.decimation;
      default: reg_read = 16'h0000;
    endcase
  endfunction : reg_read

  // edge sense follows polarity, from synchronised level only
  assign active_edge = state.misc_ctrl[CTRL_SYNC_POL] ? (state.sync_level & ~state.sync_prev)
                                                       : (~state.sync_level & state.sync_prev);
  assign other_edge = (state.sync_level != state.sync_prev) & ~active_edge;

  sample_clock_gen #(
    .PERIOD_CYCLES(SAMPLE_PERIOD_CYCLES)
  ) u_gen (
    .clk(clk),
    .reset_n(reset_n),
    .sync_edge(active_edge),
    .scale(state.clock_scale),
    .int_tick(int_tick),
    .int_half_tick(int_half_tick),
    .scaled_tick(scaled_tick)
  );

  output_decimator u_dec (
    .clk(clk),
    .reset_n(reset_n),
    .sample_tick(state.strobes.gyro),
    .divisor(state.decimation[DEC_MSB:0]),
    .out_tick(dec_tick),
    .dv_active(dv_active)
  );

  always_comb begin
    logic [6:0] addr;
    logic [6:0] word_addr;
    logic gyro;
    logic accel;
    addr = cmd.word[CMD_ADDR_MSB:CMD_ADDR_LSB];
    word_addr = {addr[6:1], 1'b0};
    gyro = 1'b0;
    accel = 1'b0;
    next_state = state;
    next_state.rd_valid = 1'b0;
    next_state.sync_meta = sync_in;
    next_state.sync_level = state.sync_meta;
    next_state.sync_prev = state.sync_level;

    if (cmd.valid && cmd.word[CMD_WRITE_BIT]) begin
      // byte writes; a half-written word is live until its partner lands
      case (word_addr)
        ADDR_MISC_CTRL: begin
          if (!addr[0]) begin
            next_state.misc_ctrl[7:0] = cmd.word[7:0];
            next_state.misc_ctrl[CTRL_UNUSED] = 1'b0;
          end
        end
        ADDR_CLOCK_SCALE: begin
          if (addr[0]) next_state.clock_scale[15:8] = cmd.word[7:0];
          else next_state.clock_scale[7:0] = cmd.word[7:0];
        end
        ADDR_DECIMATION: begin
          if (addr[0]) next_state.decimation[15:8] = cmd.word[7:0];
          else next_state.decimation[7:0] = cmd.word[7:0];
        end
        default: begin
        end
      endcase
    end else if (cmd.valid) begin
      next_state.rd_data = reg_read(word_addr, state);
      next_state.rd_valid = 1'b1;
    end

    case (state.active_mode)
      MODE_DIRECT: begin
        gyro = active_edge;
        accel = active_edge | other_edge;
      end
      MODE_PULSE: begin
        gyro = active_edge;
        accel = active_edge;
      end
      MODE_SCALED: begin
        gyro = scaled_tick;
        accel = scaled_tick;
      end
      default: begin
        gyro = int_tick;
        accel = int_half_tick;
      end
    endcase

    next_state.strobes.gyro = gyro;
    next_state.strobes.accel = accel;
    next_state.strobes.accel_pair_done = 1'b0;
    if (accel) begin
      if (state.active_mode == MODE_PULSE || state.active_mode == MODE_SCALED) begin
        next_state.strobes.accel_pair_done = 1'b1;
      end else begin
        next_state.accel_half = ~state.accel_half;
        next_state.strobes.accel_pair_done = state.accel_half;
      end
    end

    // switch only at a sample boundary; internal tick rescues a dead sync
    if (gyro || int_tick) begin
      next_state.active_mode = mode_legal(state.misc_ctrl[CTRL_MODE_MSB:CTRL_MODE_LSB]);
      // an internal tick must not split an external accel pair
      if (gyro || next_state.active_mode != state.active_mode) begin
        next_state.accel_half = 1'b0;
      end
    end

    next_state.sync_oe_n = (state.active_mode != MODE_OUTPUT);
    if (state.active_mode == MODE_OUTPUT && gyro) begin
      next_state.sync_out_cnt = SYNC_OUT_LEN;
    end else if (state.sync_out_cnt != 16'h0000) begin
      next_state.sync_out_cnt = state.sync_out_cnt - 1'b1;
    end
    next_state.sync_out = (next_state.sync_out_cnt != 16'h0000) ~^ state.misc_ctrl[CTRL_SYNC_POL];

    next_state.output_strobe = dec_tick;
    next_state.data_valid_pin = dv_active ~^ state.misc_ctrl[CTRL_DV_POL];
    next_state.linear_g = state.misc_ctrl[CTRL_LINEAR_G];
    next_state.percussion = state.misc_ctrl[CTRL_PERCUSSION];
    next_state.bw_reduced = (state.active_mode == MODE_PULSE);

    if (!reset_n) begin
      next_state = '0;
      next_state.misc_ctrl = MISC_CTRL_RESET;
      next_state.clock_scale = CLOCK_SCALE_RESET;
      next_state.decimation = DECIMATION_RESET;
      next_state.active_mode = MODE_INTERNAL;
      next_state.sync_oe_n = 1'b1;
      next_state.sync_out = 1'b0;
      next_state.data_valid_pin = 1'b0;
      next_state.linear_g = 1'b1;
      next_state.percussion = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    state <= next_state;
  end

  assign rd_data = state.rd_data;
  assign rd_valid = state.rd_valid;
  assign sync_out = state.sync_out;
  assign sync_oe_n = state.sync_oe_n;
  assign data_valid_pin = state.data_valid_pin;
  assign strobes = state.strobes;
  assign output_strobe = state.output_strobe;
  assign linear_g_comp_en = state.linear_g;
  assign percussion_align_en = state.percussion;
  assign bandwidth_reduced = state.bw_reduced;

endmodule : imu_sample_clock_sync_control
`default_nettype wire

// ===== dv/imu_sync_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module imu_sync_asserts
  import imu_sync_pkg::*;
#(
  parameter int unsigned SAMPLE_PERIOD_CYCLES = INTERNAL_PERIOD_CYCLES,
  parameter logic [1:0] GYRO_RANGE = 2'h3
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire serial_cmd_t cmd,
  input wire logic [15:0] rd_data,
  input wire logic rd_valid,
  input wire logic sync_in,
  input wire logic sync_out,
  input wire logic sync_oe_n,
  input wire logic data_valid_pin,
  input wire sample_strobes_t strobes,
  input wire logic output_strobe,
  input wire logic linear_g_comp_en,
  input wire logic percussion_align_en
);
  logic [7:0] m;
  logic [10:0] d;
  logic [11:0] gc;
  logic skip;
  logic [1:0] gs;
  wire logic wr = cmd.valid && cmd.word[15];
  wire logic rd = cmd.valid && !cmd.word[15];
  wire logic [6:0] a = cmd.word[14:8];
  // mode-dependent checks wait two gyro samples, the mode switches on a tick
  wire logic set = gs == 2'h2;
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      m <= 8'hC1;
      d <= '0;
      gc <= '0;
      skip <= 1'b0;
      gs <= 2'h2;
    end else begin
      if (wr && a == 7'h60) m <= cmd.word[7:0] & 8'hDF;
      if (wr && a == 7'h64) d[7:0] <= cmd.word[7:0];
      if (wr && a == 7'h65) d[10:8] <= cmd.word[2:0];
      gc <= output_strobe ? 12'(strobes.gyro) : gc + 12'(strobes.gyro);
      skip <= (wr && a[6:1] == 6'h32) ? 1'b1 : (output_strobe ? 1'b0 : skip);
      gs <= (wr && a == 7'h60) ? 2'h0 : ((strobes.gyro && !set) ? gs + 2'h1 : gs);
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence s_misc_wr;
    wr && a == 7'h60;
  endsequence
  a_read_answer: assert property (rd |=> rd_valid) else $error("read not answered");
  a_range_low: assert property (rd && a[6:1] == 6'h2F |=> rd_data == {12'h0, GYRO_RANGE, 2'h3})
    else $error("range id wrong");
  a_bit5_zero: assert property (rd && a[6:1] == 6'h30 |=> rd_data == {8'h0, m})
    else $error("control readback wrong");
  a_lin_comp: assert property (s_misc_wr |-> ##4 linear_g_comp_en == m[7])
    else $error("linear comp enable wrong");
  a_corner_align: assert property (s_misc_wr |-> ##4 percussion_align_en == m[6])
    else $error("alignment enable wrong");
  a_internal_pair: assert property (strobes.gyro && set && m[4:2] == 3'h0 |-> strobes.accel && strobes.accel_pair_done)
    else $error("internal accel pair missing");
  a_direct_edge: assert property ($rose(sync_in) && set && m[4:2] == 3'h1 && m[1] |-> ##[2:6] strobes.gyro)
    else $error("direct edge not sampled");
  a_sync_out_pol: assert property (strobes.gyro && set && m[4:2] == 3'h3 |-> ##[1:3] (!sync_oe_n && sync_out == m[1]))
    else $error("sync pulse missing");
  a_decim_count: assert property (output_strobe && !skip |-> gc == 12'(d) + 12'h1)
    else $error("decimation count wrong");
  a_dv_level: assert property (output_strobe |-> ##[0:2] data_valid_pin == m[0])
    else $error("data valid level wrong");
endmodule : imu_sync_asserts
bind imu_sample_clock_sync_control imu_sync_asserts #(
  .SAMPLE_PERIOD_CYCLES(SAMPLE_PERIOD_CYCLES),
  .GYRO_RANGE(GYRO_RANGE)
) chk (
  .clk(clk),
  .reset_n(reset_n),
  .cmd(cmd),
  .rd_data(rd_data),
  .rd_valid(rd_valid),
  .sync_in(sync_in),
  .sync_out(sync_out),
  .sync_oe_n(sync_oe_n),
  .data_valid_pin(data_valid_pin),
  .strobes(strobes),
  .output_strobe(output_strobe),
  .linear_g_comp_en(linear_g_comp_en),
  .percussion_align_en(percussion_align_en)
);
`default_nettype wire

// ===== dv/sync_source_model.sv
`timescale 1ns/1ps
`default_nettype none
module sync_source_model (
  input wire logic run,
  input var int hi_ns,
  input var int lo_ns,
  output logic sync_pin
);
  // pin rests low between bursts; a burst may finish one pulse after run drops
  initial begin
    sync_pin = 1'b0;
    forever begin
      wait (run);
      #(lo_ns);
      sync_pin = 1'b1;
      #(hi_ns);
      sync_pin = 1'b0;
    end
  end
endmodule : sync_source_model
`default_nettype wire

// ===== dv/imu_sample_clock_sync_control_bench.sv
`timescale 1ns/1ps
`default_nettype none
module imu_sample_clock_sync_control_bench
  import imu_sync_pkg::*;
;
  localparam int P = 40;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  serial_cmd_t cmd = '0;
  logic [15:0] rd_data;
  logic rd_valid, sync_in, sync_out, sync_oe_n, data_valid_pin, output_strobe, lin_g, perc, bw;
  sample_strobes_t strobes;
  logic run = 1'b0;
  int hi_ns = 200;
  int lo_ns = 200;
  int fails = 0;
  int samples_checked = 0;
  int cyc = 0;
  imu_sample_clock_sync_control #(.SAMPLE_PERIOD_CYCLES(P), .GYRO_RANGE(2'h1)) imu_sample_clock_sync_control_inst (
    .clk(clk), .reset_n(reset_n), .cmd(cmd), .rd_data(rd_data), .rd_valid(rd_valid),
    .sync_in(sync_in), .sync_out(sync_out), .sync_oe_n(sync_oe_n), .data_valid_pin(data_valid_pin),
    .strobes(strobes), .output_strobe(output_strobe), .linear_g_comp_en(lin_g),
    .percussion_align_en(perc), .bandwidth_reduced(bw));
  sync_source_model sync_source_model_inst (.run(run), .hi_ns(hi_ns), .lo_ns(lo_ns), .sync_pin(sync_in));
  initial begin
    forever #5 clk = ~clk;
  end
  task automatic chk(input logic ok, input string msg);
    samples_checked++;
    if (ok !== 1'b1) begin
      fails++;
      $display("CHECK FAILED %0t %s", $time, msg);
    end
  endtask : chk
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : tally_and_finish
  // ceiling sized at about three and a half times the expected run of roughly 17500 cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      chk(1'b0, "timeout");
      tally_and_finish();
    end
  end
  task automatic tx(input logic [15:0] w);
    @(negedge clk);
    cmd <= '{1'b1, w};
    @(negedge clk);
    cmd.valid <= 1'b0;
  endtask : tx
  task automatic wr16(input logic [6:0] a, input logic [15:0] v);
    tx({1'b1, a, v[7:0]});
    tx({1'b1, a | 7'h1, v[15:8]});
  endtask : wr16
  task automatic rd16(input logic [6:0] a, output logic [15:0] v);
    tx({1'b0, a, 8'h00});
    chk(rd_valid === 1'b1, "no read answer");
    v = rd_data;
  endtask : rd16
  function automatic logic near(int got, int want);
    return got >= want - 1 && got <= want + 1;
  endfunction : near
  function automatic int per_window(int win, int period);
    return win / period;
  endfunction : per_window
  initial begin
    logic [6:0] ra[5] = '{7'h5E, 7'h60, 7'h62, 7'h64, 7'h70};
    logic [15:0] rv[5] = '{16'h0007, 16'h00C1, 16'h07D0, 16'h0000, 16'h0000};
    logic [2:0] mc[6] = '{3'h0, 3'h4, 3'h3, 3'h1, 3'h5, 3'h2};
    int hn[6] = '{200, 200, 200, 200, 30, 2000};
    int gp[6] = '{40, 40, 40, 40, 40, 50};
    int ar[6] = '{2, 2, 2, 2, 1, 1};
    logic [15:0] v, r;
    int g, ac, n, oe, pd, so;
    void'($urandom(13805));
    repeat (20) @(negedge clk);
    reset_n <= 1'b1;
    @(negedge clk);
    chk(lin_g === 1'b1 && perc === 1'b1, "comp defaults");
    for (int i = 0; i < 5; i++) begin
      rd16(ra[i], v);
      chk(v === rv[i], "reset value");
    end
    $display("test reset values done");
    wr16(7'h5E, 16'hFFFF);
    rd16(7'h5E, v);
    chk(v === 16'h0007, "range id writable");
    wr16(7'h60, 16'hFF21);
    rd16(7'h60, v);
    chk(v === 16'h0001 && lin_g === 1'b0 && perc === 1'b0, "control write");
    r = 16'($urandom);
    wr16(7'h62, r);
    rd16(7'h62, v);
    chk(v === r, "scale readback");
    r = 16'($urandom % 2000);
    wr16(7'h64, r);
    rd16(7'h64, v);
    chk(v === r, "decimation readback");
    $display("test register writes done");
    for (int i = 0; i < 3; i++) begin
      r = (i == 0) ? 16'h0000 : ((i == 1) ? 16'(1 + $urandom % 4) : 16'h0007);
      wr16(7'h60, {12'h0C0, 3'h1, i[0]});
      wr16(7'h64, r);
      for (int k = 0; k < 2; k++) begin
        n = 0;
        while (output_strobe !== 1'b1 && n < 1000) begin
          @(negedge clk);
          n++;
        end
        @(negedge clk);
      end
      n = 1;
      while (output_strobe !== 1'b1 && n < 1000) begin
        @(negedge clk);
        n++;
      end
      chk(n == (r + 1) * P, "output period");
      repeat (3) @(negedge clk);
      chk(data_valid_pin === i[0], "data valid level");
      repeat (P) @(negedge clk);
      if (r != 16'h0000) chk(data_valid_pin === !i[0], "data valid not released");
    end
    $display("test decimation done");
    wr16(7'h64, 16'h0000);
    wr16(7'h62, 16'h0008);
    for (int i = 0; i < 6; i++) begin
      run = 1'b0;
      hi_ns = hn[i];
      lo_ns = 400 - hn[i] + ((i == 5) ? 3600 : 0);
      repeat (600) @(negedge clk);
      wr16(7'h60, {8'h00, 3'h6, mc[i], 2'h3});
      run = mc[i] inside {3'h1, 3'h2, 3'h5};
      repeat (1200) @(negedge clk);
      g = 0;
      ac = 0;
      oe = 0;
      pd = 0;
      so = 0;
      repeat (800) begin
        @(negedge clk);
        g += int'(strobes.gyro);
        ac += int'(strobes.accel);
        oe += int'(sync_oe_n === 1'b0);
        pd += int'(strobes.accel_pair_done === 1'b1);
        so += int'(sync_out === 1'b1);
      end
      chk(near(pd, g), "accel pairs");
      chk((mc[i] == 3'h3) ? (so > 0 && so < 800) : (so == 0), "sync pulse");
      chk(near(g, per_window(800, gp[i])), "gyro rate");
      if (ar[i] != 0) chk(near(ac, ar[i] * g), "accel rate");
      chk((bw === 1'b1) == (mc[i] == 3'h5), "bandwidth");
      chk((oe > 0) == (mc[i] == 3'h3), "sync drive");
      $display("test mode %0d done", mc[i]);
    end
    run = 1'b0;
    tally_and_finish();
  end
endmodule : imu_sample_clock_sync_control_bench
`default_nettype wire
